/* File: hdl/dso_map.vh */
// Constants for the deserializer output, strap and control block
`ifndef DSO_MAP_VH
`define DSO_MAP_VH
// System clock and timing
`define DSO_MCLK_KHZ 40000
`define DSO_STRAP_SETTLE_NS 1000
`define DSO_FILT_MIN_CLKS 3
// Register offsets (byte addresses)
`define DSO_REG_CFG 8'h00
`define DSO_REG_STAT 8'h04
`define DSO_REG_IRQ_STAT 8'h08
`define DSO_REG_IRQ_CLR 8'h0c
`define DSO_REG_IRQ_EN 8'h10
`define DSO_REG_HOLD_REL 8'h14
`define DSO_REG_STRAP 8'h18
// Configuration word field positions
`define DSO_CFG_W 21
`define DSO_CFG_MODE_LO 0
`define DSO_CFG_MODE_HI 1
`define DSO_CFG_LOWBAND 2
`define DSO_CFG_CSLEW 3
`define DSO_CFG_DSLEW 4
`define DSO_CFG_OSS 5
`define DSO_CFG_EDGE 6
`define DSO_CFG_EQ_LO 7
`define DSO_CFG_EQ_HI 10
`define DSO_CFG_OSC_LO 11
`define DSO_CFG_OSC_HI 13
`define DSO_CFG_SSC_LO 14
`define DSO_CFG_SSC_HI 17
`define DSO_CFG_MAP_LO 18
`define DSO_CFG_MAP_HI 19
`define DSO_CFG_SPREAD_SPECTRUM_GEN 20
`define DSO_CFG_OVR 31
`define DSO_CFG_RESET 21'h000000
// Filter and compatibility select codes
`define DSO_MODE_NOFILT 2'b00
`define DSO_MODE_FILT 2'b01
`define DSO_MODE_COMPAT_A 2'b10
`define DSO_MODE_COMPAT_B 2'b11
// Interrupt status bits
`define DSO_IRQ_W 3
`define DSO_IRQ_LOCK_UP 0
`define DSO_IRQ_LOCK_DN 1
`define DSO_IRQ_BIST_ERR 2
`endif

/* File: hdl/dso_deser_ctrl.v */
// Deserializer strap capture, power-down and output gating logic
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Sample shared data pins as straps before driving
// - Power-down low resets registers, sets sleep outputs
// - Power-down high enables receive and output logic
// - Lock status gates outputs; unlocked uses sleep state
// - Self-test pass high until payload error seen
// - Decode filter and compatibility select codes
// - Filter drops DE/HSYNC pulses under 3 clocks
// - VSYNC unfiltered, sampled on every link clock
// - Strobe select picks rising or falling alignment
// - Low band select only matters with spread on
// - Hold-low strap keeps outputs low until release
// - Without hold-low, outputs toggle once locked
// - Self-test enable input turns self-test on
// - Bit-map select defaults 00, strap or register
// - Register override replaces every strap setting except hold-low
`include "dso_map.vh"
module dso_deser_ctrl (
    input wire mclk, // System clock
    input wire nrst, // Async reset, active low
    input wire power_down_n, // Power-down pin, low powers down
    input wire selftest_enable, // Self-test enable pin
    input wire link_clk, // Recovered link clock
    input wire link_lock, // Recovered clock locked
    input wire [23:0] link_data, // Received pixel word
    input wire link_de, // Received data enable
    input wire link_hsync, // Received horizontal sync
    input wire link_vsync, // Received vertical sync
    input wire link_err, // Payload error flag, self-test
    input wire [23:0] do_in, // Data pin input side
    output reg [23:0] do_out, // Data pin output value
    output reg [23:0] do_oe, // Data pin output enable
    input wire pass_in, // Pass pin input side
    output reg pass_out, // Pass pin output value
    output reg pass_oe, // Pass pin output enable
    output reg ctl_out_de, // Data enable output
    output reg ctl_out_hsync, // Horizontal sync output
    output reg ctl_out_vsync, // Vertical sync output
    output reg pixel_clock_out, // Pixel clock output
    output reg lock_out, // Link acquired status
    output reg [3:0] rx_equalizer_sel, // Equalizer setting
    output reg [2:0] oscillator_sel, // Oscillator setting
    output reg [3:0] spread_range_sel, // Spread range setting
    output reg spread_spectrum_gen, // Spread spectrum enable
    output reg spread_low_band, // Spread low band select
    output reg pixclk_slew_sel, // Pixel clock slew select
    output reg dataout_slew_sel, // Data slew select
    output reg [1:0] map_sel, // Bit mapping select
    output reg [1:0] compat_mode, // Filter/compatibility code
    input wire [7:0] reg_addr, // Register byte address
    input wire [31:0] reg_wdata, // Register write data
    input wire reg_wr, // Register write strobe
    input wire reg_rd, // Register read strobe
    output reg [31:0] reg_rdata, // Register read data
    output reg irq // Interrupt, active high level
);

    localparam ST_OFF = 2'd0;
    localparam ST_STRAP = 2'd1;
    localparam ST_RUN = 2'd2;
    localparam integer SETTLE_CYC = (`DSO_STRAP_SETTLE_NS * `DSO_MCLK_KHZ
        + 999999) / 1000000;
    localparam integer FILT_MIN = `DSO_FILT_MIN_CLKS;
    localparam [2:0] FILT_LAST = FILT_MIN[2:0] - 3'd1;

    // Filter step: returns {take new level, next count}
    function [3:0] filt_step;
        input [2:0] cnt;
        input raw;
        input cur;
        input en;
        begin
            if (raw == cur) begin
                filt_step = 4'h0;
            end else if (!en || cnt == FILT_LAST) begin
                filt_step = 4'h8;
            end else begin
                filt_step = {1'b0, cnt + 3'd1};
            end
        end
    endfunction

    reg [56:0] in_s1_q;
    reg [56:0] in_s2_q;
    reg clk_s3_q;
    reg [1:0] state_q;
    reg [5:0] settle_q;
    reg [`DSO_CFG_W-1:0] strap_q;
    reg [`DSO_CFG_W-1:0] cfg_q;
    reg ovr_q;
    reg hold_q;
    reg [`DSO_IRQ_W-1:0] ist_q;
    reg [`DSO_IRQ_W-1:0] ien_q;
    reg lock_d1_q;
    reg pass_q;
    reg de_f_q;
    reg hs_f_q;
    reg [2:0] de_cnt_q;
    reg [2:0] hs_cnt_q;
    reg [23:0] stg_data_q;
    reg stg_de_q;
    reg stg_hs_q;
    reg stg_vs_q;
    reg rise_d1_q;

    wire pd_s = in_s2_q[0];
    wire bist_s = in_s2_q[1];
    wire clk_s = in_s2_q[2];
    wire lock_s = in_s2_q[3];
    wire de_s = in_s2_q[4];
    wire hs_s = in_s2_q[5];
    wire vs_s = in_s2_q[6];
    wire err_s = in_s2_q[7];
    wire [23:0] data_s = in_s2_q[31:8];
    wire [23:0] pin_s = in_s2_q[55:32];
    wire pass_s = in_s2_q[56];
    wire rise_ev = clk_s & ~clk_s3_q;
    wire fall_ev = ~clk_s & clk_s3_q;
    wire run = (state_q == ST_RUN);
    wire [`DSO_CFG_W-1:0] cfg_eff = ovr_q ? cfg_q : strap_q;
    wire filt_en = (cfg_eff[`DSO_CFG_MODE_HI:`DSO_CFG_MODE_LO]
        == `DSO_MODE_FILT);
    wire edge_rise = cfg_eff[`DSO_CFG_EDGE];
    wire oss = cfg_eff[`DSO_CFG_OSS];
    wire pres_ev = edge_rise ? fall_ev : rise_d1_q;
    wire [3:0] de_step = filt_step(de_cnt_q, de_s, de_f_q, filt_en);
    wire [3:0] hs_step = filt_step(hs_cnt_q, hs_s, hs_f_q, filt_en);
    wire bist_err = run & bist_s & lock_s & rise_ev & err_s;
    wire [`DSO_IRQ_W-1:0] ev = {bist_err & pass_q,
        lock_d1_q & ~lock_s & run, ~lock_d1_q & lock_s & run};
    // Strap word in configuration layout; spread enable has no strap
    wire [`DSO_CFG_W-1:0] strap_word = {1'b0, pin_s[1], pin_s[0],
        pin_s[6:3], pin_s[10:8], pin_s[15:12], pin_s[17], pin_s[18],
        pin_s[19], pin_s[21], pin_s[20], pin_s[22], pin_s[23]};

    // Two-stage synchronisers for every pin and link input
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            in_s1_q <= 57'h0;
            in_s2_q <= 57'h0;
            clk_s3_q <= 1'b0;
        end else begin
            in_s1_q <= {pass_in, do_in, link_data, link_err, link_vsync,
                link_hsync, link_de, link_lock, link_clk,
                selftest_enable, power_down_n};
            in_s2_q <= in_s1_q;
            clk_s3_q <= in_s2_q[2];
        end
    end

    // Power sequence: off, strap settle and capture, run
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_OFF;
            settle_q <= 6'h0;
            strap_q <= `DSO_CFG_RESET;
            hold_q <= 1'b0;
        end else if (!pd_s) begin
            state_q <= ST_OFF;
            settle_q <= 6'h0;
            hold_q <= 1'b0;
        end else begin
            case (state_q)
                ST_OFF: begin
                    state_q <= ST_STRAP;
                    settle_q <= 6'h0;
                end
                ST_STRAP: begin
                    if (settle_q == SETTLE_CYC[5:0] - 6'h1) begin
                        strap_q <= strap_word;
                        hold_q <= pass_s;
                        state_q <= ST_RUN;
                    end else begin
                        settle_q <= settle_q + 6'h1;
                    end
                end
                ST_RUN: begin
                    if (reg_wr && reg_addr == `DSO_REG_HOLD_REL
                        && reg_wdata[0]) begin
                        hold_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    // Software registers; power-down clears them all
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= `DSO_CFG_RESET;
            ovr_q <= 1'b0;
            ien_q <= 3'h0;
            ist_q <= 3'h0;
        end else if (!pd_s) begin
            cfg_q <= `DSO_CFG_RESET;
            ovr_q <= 1'b0;
            ien_q <= 3'h0;
            ist_q <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == `DSO_REG_CFG) begin
                cfg_q <= reg_wdata[`DSO_CFG_W-1:0];
                ovr_q <= reg_wdata[`DSO_CFG_OVR];
            end
            if (reg_wr && reg_addr == `DSO_REG_IRQ_EN) begin
                ien_q <= reg_wdata[`DSO_IRQ_W-1:0];
            end
            // A new event wins over a clear in the same cycle
            if (reg_wr && reg_addr == `DSO_REG_IRQ_CLR) begin
                ist_q <= (ist_q & ~reg_wdata[`DSO_IRQ_W-1:0]) | ev;
            end else begin
                ist_q <= ist_q | ev;
            end
        end
    end

    // Register read data, valid only in the cycle after the strobe
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `DSO_REG_CFG: reg_rdata <= {ovr_q, 10'h0, cfg_q};
                `DSO_REG_STAT: reg_rdata <= {26'h0, state_q, bist_s,
                    hold_q, pass_q, lock_s};
                `DSO_REG_IRQ_STAT: reg_rdata <= {29'h0, ist_q};
                `DSO_REG_IRQ_EN: reg_rdata <= {29'h0, ien_q};
                `DSO_REG_STRAP: reg_rdata <= {11'h0, strap_q};
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // Lock history, self-test result and interrupt line
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lock_d1_q <= 1'b0;
            pass_q <= 1'b1;
            irq <= 1'b0;
        end else begin
            lock_d1_q <= lock_s & run;
            irq <= |(ist_q & ien_q);
            if (!run || !bist_s) begin
                pass_q <= 1'b1;
            end else if (bist_err) begin
                pass_q <= 1'b0;
            end
        end
    end

    // Control filter on DE and HSYNC; VSYNC passes untouched
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            de_f_q <= 1'b0;
            hs_f_q <= 1'b0;
            de_cnt_q <= 3'h0;
            hs_cnt_q <= 3'h0;
            stg_data_q <= 24'h0;
            stg_de_q <= 1'b0;
            stg_hs_q <= 1'b0;
            stg_vs_q <= 1'b0;
            rise_d1_q <= 1'b0;
        end else begin
            rise_d1_q <= rise_ev;
            if (rise_ev) begin
                de_cnt_q <= de_step[2:0];
                hs_cnt_q <= hs_step[2:0];
                stg_data_q <= data_s;
                stg_de_q <= de_step[3] ? de_s : de_f_q;
                stg_hs_q <= hs_step[3] ? hs_s : hs_f_q;
                stg_vs_q <= vs_s;
                if (de_step[3]) begin
                    de_f_q <= de_s;
                end
                if (hs_step[3]) begin
                    hs_f_q <= hs_s;
                end
            end
        end
    end

    // Pin drivers: strap window, sleep state, hold-low and live data
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            do_out <= 24'h0;
            do_oe <= 24'h0;
            pass_out <= 1'b0;
            pass_oe <= 1'b0;
            ctl_out_de <= 1'b0;
            ctl_out_hsync <= 1'b0;
            ctl_out_vsync <= 1'b0;
            pixel_clock_out <= 1'b0;
            lock_out <= 1'b0;
        end else if (state_q == ST_STRAP) begin
            do_oe <= 24'h0;
            pass_oe <= 1'b0;
            do_out <= 24'h0;
            pass_out <= 1'b0;
            ctl_out_de <= 1'b0;
            ctl_out_hsync <= 1'b0;
            ctl_out_vsync <= 1'b0;
            pixel_clock_out <= 1'b0;
            lock_out <= 1'b0;
        end else if (!run || hold_q || !lock_s) begin
            // Sleep state: 0 drives low, pass pin only while running; 1 releases the pins
            do_out <= 24'h0;
            do_oe <= {24{hold_q | ~oss}};
            pass_out <= 1'b0;
            pass_oe <= hold_q | (run & ~oss);
            ctl_out_de <= 1'b0;
            ctl_out_hsync <= 1'b0;
            ctl_out_vsync <= 1'b0;
            pixel_clock_out <= 1'b0;
            lock_out <= run & lock_s & ~hold_q;
        end else begin
            do_oe <= 24'hffffff;
            pass_oe <= 1'b1;
            pass_out <= pass_q;
            lock_out <= 1'b1;
            pixel_clock_out <= clk_s3_q;
            if (pres_ev) begin
                do_out <= stg_data_q;
                ctl_out_de <= stg_de_q;
                ctl_out_hsync <= stg_hs_q;
                ctl_out_vsync <= stg_vs_q;
            end
        end
    end

    // Effective configuration to the analog and clocking blocks
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_equalizer_sel <= 4'h0;
            oscillator_sel <= 3'h0;
            spread_range_sel <= 4'h0;
            spread_spectrum_gen <= 1'b0;
            spread_low_band <= 1'b0;
            pixclk_slew_sel <= 1'b0;
            dataout_slew_sel <= 1'b0;
            map_sel <= 2'h0;
            compat_mode <= 2'h0;
        end else begin
            rx_equalizer_sel <= cfg_eff[`DSO_CFG_EQ_HI:`DSO_CFG_EQ_LO];
            oscillator_sel <= cfg_eff[`DSO_CFG_OSC_HI:`DSO_CFG_OSC_LO];
            spread_range_sel <=
                cfg_eff[`DSO_CFG_SSC_HI:`DSO_CFG_SSC_LO];
            spread_spectrum_gen <= cfg_eff[`DSO_CFG_SPREAD_SPECTRUM_GEN];
            spread_low_band <= cfg_eff[`DSO_CFG_SPREAD_SPECTRUM_GEN]
                & cfg_eff[`DSO_CFG_LOWBAND];
            pixclk_slew_sel <= cfg_eff[`DSO_CFG_CSLEW];
            dataout_slew_sel <= cfg_eff[`DSO_CFG_DSLEW];
            map_sel <= cfg_eff[`DSO_CFG_MAP_HI:`DSO_CFG_MAP_LO];
            compat_mode <=
                cfg_eff[`DSO_CFG_MODE_HI:`DSO_CFG_MODE_LO];
        end
    end

endmodule // dso_deser_ctrl

/* File: sim/dso_deser_ctrl_assertions.sv */
// Port-level checker for the deserializer strap and output gating block
`timescale 1ns/1ps
module dso_deser_ctrl_chk (
    input wire logic mclk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic power_down_n, // Power-down pin
    input wire logic selftest_enable, // Self-test pin
    input wire logic link_lock, // Link lock in
    input wire logic [23:0] do_oe, // Data pin enables
    input wire logic pass_out, // Pass pin value
    input wire logic pass_oe, // Pass pin enable
    input wire logic ctl_out_de, // Data enable out
    input wire logic ctl_out_hsync, // Hsync out
    input wire logic ctl_out_vsync, // Vsync out
    input wire logic pixel_clock_out, // Pixel clock out
    input wire logic lock_out, // Status out
    input wire logic spread_spectrum_gen, // Spread enable
    input wire logic spread_low_band, // Low band select
    input wire logic [1:0] map_sel, // Bit map select
    input wire logic [1:0] compat_mode, // Mode code
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [31:0] reg_rdata, // Read data
    input wire logic irq // Interrupt
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // Pins float while straps are read
    property p_strap_float;
        $rose(power_down_n) |-> ##5 (do_oe == 24'h0) && !pass_oe;
    endproperty
    a_strap_float: assert property (p_strap_float)
        else $error("data pins driven during strap read");
    // Power-down gives sleep outputs and no status
    property p_pd_sleep;
        !power_down_n [*5] |-> !lock_out
            && (do_oe == 24'hffffff || do_oe == 24'h0);
    endproperty
    a_pd_sleep: assert property (p_pd_sleep)
        else $error("outputs not in sleep state in power-down");
    // Loss of lock drops the status
    property p_unlock;
        !link_lock [*4] |-> !lock_out;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("status high without lock");
    // Inactive outputs stay low
    property p_ctl_idle;
        !lock_out [*2] |-> !(ctl_out_de || ctl_out_hsync || ctl_out_vsync
            || pixel_clock_out);
    endproperty
    a_ctl_idle: assert property (p_ctl_idle)
        else $error("control outputs active while inactive");
    // Pass stays high outside self-test
    property p_pass_idle;
        lock_out && !selftest_enable [*5] |-> pass_out;
    endproperty
    a_pass_idle: assert property (p_pass_idle)
        else $error("pass low outside self-test");
    // Low band only with spread on
    property p_lowband;
        !spread_spectrum_gen |-> !spread_low_band;
    endproperty
    a_lowband: assert property (p_lowband)
        else $error("low band set without spread");
    // Settings hold while running and no write is made
    property p_cfg_hold;
        (power_down_n [*4]) ##0 (lock_out && !reg_wr && !$past(reg_wr))
            |=> $stable(compat_mode) && $stable(map_sel);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("settings changed without a write");
    // Read data only after a read strobe
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without a read");
    c_lock: cover property ($rose(lock_out));
    c_irq: cover property ($rose(irq));
    c_de: cover property ($rose(ctl_out_de));
    c_band: cover property ($rose(spread_low_band));
endmodule // dso_deser_ctrl_chk
bind dso_deser_ctrl dso_deser_ctrl_chk u_dso_deser_ctrl_chk (.*);

/* File: sim/dso_ser_model.sv */
// Serializer-side link source model
`timescale 1ns/1ps
module dso_ser_model (
    input wire logic run, // Link active
    input wire logic [23:0] nx_data, // Next word
    input wire logic nx_de, // Next data enable
    input wire logic nx_hs, // Next hsync
    input wire logic nx_vs, // Next vsync
    input wire logic nx_err, // Next payload error
    output logic link_clk, // Link clock
    output logic link_lock, // Lock seen by receiver
    output logic [23:0] link_data, // Word
    output logic link_de, // Data enable
    output logic link_hsync, // Hsync
    output logic link_vsync, // Vsync
    output logic link_err // Payload error
);
    logic [2:0] lk_cnt;
    // Clock stands still low while the link is idle
    initial begin
        link_clk = 1'b0;
        link_lock = 1'b0;
        lk_cnt = 3'h0;
        #37;
        forever begin
            #100;
            link_clk = run ? ~link_clk : 1'b0;
        end
    end
    // Lock after five link clocks, lost at once when idle
    always @(posedge link_clk or negedge run) begin
        if (!run) begin
            lk_cnt <= 3'h0;
            link_lock <= 1'b0;
        end else if (lk_cnt == 3'h4) begin
            link_lock <= 1'b1;
        end else begin
            lk_cnt <= lk_cnt + 3'h1;
        end
    end
    // Words launched mid-period; pacing comes from the bench
    always @(negedge link_clk) begin
        link_data <= nx_data;
        link_de <= nx_de;
        link_hsync <= nx_hs;
        link_vsync <= nx_vs;
        link_err <= nx_err;
    end
    // Released data lines do not keep the last word
    always @(negedge run) begin
        link_data <= ~link_data;
    end
endmodule // dso_ser_model

/* File: sim/dso_deser_ctrl_tb.sv */
// Testbench for the deserializer strap and output gating block
`timescale 1ns/1ps
`include "dso_map.vh"
module dso_deser_ctrl_tb;
    logic mclk, nrst, power_down_n, selftest_enable, run, de_seen;
    logic link_clk, link_lock, link_de, link_hsync, link_vsync, link_err;
    logic [23:0] link_data, nx_data, do_in, do_out, do_oe, strap_do;
    logic nx_de, nx_hs, nx_vs, nx_err, pass_in, pass_out, pass_oe, strap_pass;
    logic ctl_out_de, ctl_out_hsync, ctl_out_vsync, pixel_clock_out, lock_out;
    logic [3:0] rx_equalizer_sel, spread_range_sel;
    logic [2:0] oscillator_sel;
    logic spread_spectrum_gen, spread_low_band, pixclk_slew_sel;
    logic dataout_slew_sel, reg_wr, reg_rd, irq;
    logic [1:0] map_sel, compat_mode;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    int miscompares, total_checks;
    // Pin levels: driven value where enabled, strap level elsewhere
    assign do_in = (do_oe & do_out) | (~do_oe & strap_do);
    assign pass_in = pass_oe ? pass_out : strap_pass;
    dso_deser_ctrl u_dso_deser_ctrl (.*);
    dso_ser_model u_dso_ser_model (.*);
    // System clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Remembers any DE or HSYNC pulse reaching the outputs
    always @(posedge mclk) begin
        if (ctl_out_de === 1'b1 || ctl_out_hsync === 1'b1) de_seen = 1'b1;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk(reg_rdata, exp);
    endtask
    task automatic lk(input int n, input logic [23:0] d, input logic de,
                      input logic vs, input logic err);
        repeat (n) begin
            @(posedge link_clk);
            nx_data = d;
            nx_de = de;
            nx_hs = de;
            nx_vs = vs;
            nx_err = err;
        end
    endtask
    // Control pulse of w words, then a long quiet gap
    task automatic pulse(input int w, input logic exp);
        de_seen = 1'b0;
        lk(w, 24'h0, 1'b1, 1'b0, 1'b0);
        lk(131, 24'h0, 1'b0, 1'b0, 1'b0);
        chk({31'h0, de_seen}, {31'h0, exp});
    endtask
    // Hang guard
    initial begin
        #400000;
        miscompares++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {nrst, power_down_n, selftest_enable, run, de_seen} = 5'h0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 42'h0;
        {nx_data, nx_de, nx_hs, nx_vs, nx_err} = 28'h0;
        strap_do = 24'h80a502;
        strap_pass = 1'b0;
        miscompares = 0;
        total_checks = 0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        power_down_n <= 1'b1;
        cyc(50);
        chk({21'h0, compat_mode, map_sel, rx_equalizer_sel, oscillator_sel},
            32'h355);
        rdc(`DSO_REG_STRAP, 32'h82d01);
        run = 1'b1;
        cyc(60);
        chk({31'h0, lock_out}, 32'h1);
        wr(`DSO_REG_IRQ_EN, 32'h0);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(`DSO_REG_IRQ_EN, 32'h7);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        wr(`DSO_REG_IRQ_CLR, 32'h7);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        rdc(`DSO_REG_IRQ_STAT, 32'h0);
        rdc(8'h1c, 32'h0);
        lk(140, 24'h5a3c96, 1'b0, 1'b1, 1'b0);
        cyc(4);
        chk({8'h0, do_out}, 32'h5a3c96);
        chk({31'h0, ctl_out_vsync}, 32'h1);
        lk(131, 24'h0, 1'b0, 1'b0, 1'b0);
        pulse(1, 1'b0);
        pulse(4, 1'b1);
        wr(`DSO_REG_CFG, 32'h80000000);
        pulse(1, 1'b1);
        wr(`DSO_REG_CFG, 32'h8011401c);
        cyc(2);
        chk({24'h0, spread_range_sel, pixclk_slew_sel, dataout_slew_sel,
            spread_spectrum_gen, spread_low_band}, 32'h5f);
        // Rising-edge strobe: data moves on the link's falling edge
        wr(`DSO_REG_CFG, 32'h80000044);
        cyc(2);
        chk({31'h0, spread_low_band}, 32'h0);
        lk(2, 24'h3c5a69, 1'b0, 1'b0, 1'b0);
        cyc(4);
        chk({8'h0, do_out}, 32'h0);
        cyc(4);
        chk({8'h0, do_out}, 32'h3c5a69);
        @(posedge mclk);
        selftest_enable <= 1'b1;
        lk(4, 24'h0, 1'b0, 1'b0, 1'b0);
        cyc(4);
        chk({31'h0, pass_out}, 32'h1);
        lk(1, 24'h0, 1'b0, 1'b0, 1'b1);
        lk(4, 24'h0, 1'b0, 1'b0, 1'b0);
        cyc(4);
        chk({31'h0, pass_out}, 32'h0);
        rdc(`DSO_REG_IRQ_STAT, 32'h4);
        @(posedge mclk);
        selftest_enable <= 1'b0;
        cyc(6);
        chk({31'h0, pass_out}, 32'h1);
        run = 1'b0;
        cyc(10);
        chk({31'h0, lock_out}, 32'h0);
        chk({do_oe, 8'h0} | {8'h0, do_out}, 32'hffffff00);
        chk({31'h0, irq}, 32'h1);
        rdc(`DSO_REG_IRQ_STAT, 32'h6);
        @(posedge mclk);
        power_down_n <= 1'b0;
        cyc(5);
        chk({8'h0, do_oe}, 32'hffffff);
        strap_do = 24'h0;
        strap_pass = 1'b1;
        @(posedge mclk);
        power_down_n <= 1'b1;
        run = 1'b1;
        cyc(100);
        chk({31'h0, lock_out}, 32'h0);
        chk({6'h0, pass_oe, pass_out, do_oe}, 32'h2ffffff);
        rdc(`DSO_REG_CFG, 32'h0);
        wr(`DSO_REG_HOLD_REL, 32'h1);
        cyc(4);
        chk({31'h0, lock_out}, 32'h1);
        tally_and_finish();
    end
endmodule // dso_deser_ctrl_tb
